// [core/dsos_pkg.sv]
// Function
// - ready output needs ready and no alarm
// - power output follows control power only
// - zero speed when speed at or below threshold
// - threshold defaults 10 rpm, holds until above
// - target speed held from reached until below
// - external pulse mode: error within window
// - internal register mode: position within window band
// - torque limit reached, not torque modes
// - alarm output while any alarm present
// - listed faults raise warning before alarm
// - brake output timed by brake delays
package dsos_pkg;

    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int NUM_DO = 8;
    localparam int CODE_W = 8;
    localparam int SEL_W = 3;
    localparam int SPEED_W = 16;
    localparam int POS_W = 32;
    localparam int TORQUE_W = 16;
    localparam int DELAY_W = 16;
    localparam int NUM_WARN = 5;

    // ----------------------------------------------------------------
    // output function codes
    // ----------------------------------------------------------------
    localparam logic [CODE_W-1:0] FN_DISABLED = 8'h00;
    localparam logic [CODE_W-1:0] FN_READY = 8'h01;
    localparam logic [CODE_W-1:0] FN_POWER_ON = 8'h02;
    localparam logic [CODE_W-1:0] FN_ZERO_SPEED = 8'h03;
    localparam logic [CODE_W-1:0] FN_TARGET_SPEED = 8'h04;
    localparam logic [CODE_W-1:0] FN_IN_POSITION = 8'h05;
    localparam logic [CODE_W-1:0] FN_TORQUE_LIMIT = 8'h06;
    localparam logic [CODE_W-1:0] FN_ALARM = 8'h07;
    localparam logic [CODE_W-1:0] FN_BRAKE = 8'h08;
    localparam logic [CODE_W-1:0] CODE_RESET = 8'h00;

    // ----------------------------------------------------------------
    // control mode codes
    // ----------------------------------------------------------------
    localparam logic [2:0] MODE_EXT_PULSE = 3'h0;
    localparam logic [2:0] MODE_INT_REG = 3'h1;
    localparam logic [2:0] MODE_SPEED = 3'h2;
    localparam logic [2:0] MODE_TORQUE = 3'h3;
    localparam logic [2:0] MODE_SPEED_ZERO = 3'h4;
    localparam logic [2:0] MODE_TORQUE_ZERO = 3'h5;

    // ----------------------------------------------------------------
    // parameter defaults and timing
    // ----------------------------------------------------------------
    localparam logic [SPEED_W-1:0] ZERO_SPEED_DEFAULT_RPM = 16'h000A;
    localparam int CLOCK_MHZ = 100;
    localparam int MS_PER_TICK = 1;
    localparam int CYCLES_PER_MS = CLOCK_MHZ * 1000 * MS_PER_TICK;
    localparam int MS_CNT_W = 17;

endpackage

// [core/dsos_brake_timer.sv]
`timescale 1ns/100ps
module dsos_brake_timer #(
    parameter int CYCLES_PER_MS = dsos_pkg::CYCLES_PER_MS
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // request and delays in ms
    input wire logic brakeRequest,
    input wire logic [dsos_pkg::DELAY_W-1:0] brakeOnDelay,
    input wire logic [dsos_pkg::DELAY_W-1:0] brakeOffDelay,
    // brake actuation level
    output logic brakeActive
);

    typedef enum logic [1:0] {RELEASED, ENGAGE_WAIT, ENGAGED, RELEASE_WAIT} dsos_brake_t;

    dsos_brake_t state_q, state_d;
    logic [dsos_pkg::MS_CNT_W-1:0] tick_q, tick_d;
    logic [dsos_pkg::DELAY_W-1:0] ms_q, ms_d;
    logic msTick;

    // ms prescaler runs only while a delay is pending
    assign msTick = (tick_q == dsos_pkg::MS_CNT_W'(CYCLES_PER_MS - 1));

    // ----------------------------------------------------------------
    // delay sequencer
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        tick_d = tick_q;
        ms_d = ms_q;
        case (state_q)
            RELEASED: begin
                tick_d = '0;
                ms_d = '0;
                if (brakeRequest) begin
                    state_d = (brakeOnDelay == '0) ? ENGAGED : ENGAGE_WAIT;
                end
            end
            ENGAGE_WAIT: begin
                tick_d = msTick ? '0 : tick_q + 1'b1;
                if (msTick) begin
                    ms_d = ms_q + 1'b1;
                end
                if (!brakeRequest) begin
                    state_d = RELEASED;
                end else if (msTick && (ms_q + 1'b1 >= brakeOnDelay)) begin
                    state_d = ENGAGED;
                end
            end
            ENGAGED: begin
                tick_d = '0;
                ms_d = '0;
                if (!brakeRequest) begin
                    state_d = (brakeOffDelay == '0) ? RELEASED : RELEASE_WAIT;
                end
            end
            RELEASE_WAIT: begin
                tick_d = msTick ? '0 : tick_q + 1'b1;
                if (msTick) begin
                    ms_d = ms_q + 1'b1;
                end
                if (brakeRequest) begin
                    state_d = ENGAGED;
                end else if (msTick && (ms_q + 1'b1 >= brakeOffDelay)) begin
                    state_d = RELEASED;
                end
            end
            default: begin
                state_d = RELEASED;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= RELEASED;
            tick_q <= '0;
            ms_q <= '0;
        end else begin
            state_q <= state_d;
            tick_q <= tick_d;
            ms_q <= ms_d;
        end
    end

    // brake held through the release delay
    assign brakeActive = (state_q == ENGAGED) || (state_q == RELEASE_WAIT);

endmodule

// [core/dsos_output_select.sv]
`timescale 1ns/100ps
module dsos_output_select #(
    parameter int CYCLES_PER_MS = dsos_pkg::CYCLES_PER_MS
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // function code load
    input wire logic codeWrite,
    input wire logic [dsos_pkg::SEL_W-1:0] codeIndex,
    input wire logic [dsos_pkg::CODE_W-1:0] codeValue,
    // drive state
    input wire logic [2:0] controlMode,
    input wire logic controlPowerOn,
    input wire logic driveReady,
    input wire logic otherAlarm,
    input wire logic [dsos_pkg::NUM_WARN-1:0] warnFaults,
    // speed
    input wire logic [dsos_pkg::SPEED_W-1:0] motorSpeed,
    input wire logic zeroSpeedLoad,
    input wire logic [dsos_pkg::SPEED_W-1:0] zeroSpeedValue,
    input wire logic [dsos_pkg::SPEED_W-1:0] targetSpeedSetting,
    // position
    input wire logic signed [dsos_pkg::POS_W-1:0] positionError,
    input wire logic signed [dsos_pkg::POS_W-1:0] motorPosition,
    input wire logic signed [dsos_pkg::POS_W-1:0] targetPosition,
    input wire logic [dsos_pkg::POS_W-2:0] inPositionWindow,
    // torque
    input wire logic signed [dsos_pkg::TORQUE_W-1:0] motorTorque,
    input wire logic [dsos_pkg::TORQUE_W-2:0] torqueLimitFirst,
    input wire logic [dsos_pkg::TORQUE_W-2:0] torqueLimitLast,
    input wire logic useAnalogLimit,
    input wire logic [dsos_pkg::TORQUE_W-2:0] analogTorqueLimit,
    // brake
    input wire logic brakeRequest,
    input wire logic [dsos_pkg::DELAY_W-1:0] brakeOnDelay,
    input wire logic [dsos_pkg::DELAY_W-1:0] brakeOffDelay,
    // outputs
    output logic [dsos_pkg::NUM_DO-1:0] digitalOut,
    output logic warningOut,
    output logic [dsos_pkg::SPEED_W-1:0] zeroSpeedThreshold
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [dsos_pkg::CODE_W-1:0] code_q [dsos_pkg::NUM_DO];
    logic [dsos_pkg::CODE_W-1:0] code_d [dsos_pkg::NUM_DO];
    logic [dsos_pkg::NUM_DO-1:0] out_q, out_d;
    logic warn_q, warn_d;
    logic warnSeen_q, warnSeen_d;
    logic [dsos_pkg::SPEED_W-1:0] zeroThr_q, zeroThr_d;

    logic condReady, condPower, condZero, condTarget;
    logic condInPos, condTorque, condAlarm, condBrake;
    logic brakeActive;
    logic [dsos_pkg::POS_W-1:0] errMag;
    logic signed [dsos_pkg::POS_W:0] posDiff;
    logic [dsos_pkg::POS_W:0] diffMag;
    logic [dsos_pkg::TORQUE_W-1:0] torqueMag;
    logic [dsos_pkg::TORQUE_W-2:0] limitSel;
    logic torqueMode;

    // ----------------------------------------------------------------
    // brake delay timing
    // ----------------------------------------------------------------
    dsos_brake_timer #(
        .CYCLES_PER_MS(CYCLES_PER_MS)
    ) u_brake (
        .clock(clock),
        .rst_n(rst_n),
        .brakeRequest(brakeRequest),
        .brakeOnDelay(brakeOnDelay),
        .brakeOffDelay(brakeOffDelay),
        .brakeActive(brakeActive)
    );

    // ----------------------------------------------------------------
    // status conditions
    // ----------------------------------------------------------------
    assign condAlarm = otherAlarm || warnSeen_q;
    assign condReady = driveReady && !condAlarm;
    assign condPower = controlPowerOn;
    assign condZero = (motorSpeed <= zeroThr_q);
    assign condTarget = (motorSpeed >= targetSpeedSetting);
    assign condBrake = brakeActive;

    // magnitudes for the in-position windows
    assign errMag = positionError[dsos_pkg::POS_W-1] ? 32'(-positionError) : 32'(positionError);
    assign posDiff = 33'(motorPosition) - 33'(targetPosition);
    assign diffMag = posDiff[dsos_pkg::POS_W] ? 33'(-posDiff) : 33'(posDiff);

    // in-position per control mode
    always_comb begin
        condInPos = 1'b0;
        if (controlMode == dsos_pkg::MODE_EXT_PULSE) begin
            condInPos = (errMag <= 32'(inPositionWindow));
        end else if (controlMode == dsos_pkg::MODE_INT_REG) begin
            condInPos = (diffMag <= 33'(inPositionWindow));
        end
    end

    // torque limit, analog limit if selected, else forward uses first limit, reverse the last
    assign torqueMode = (controlMode == dsos_pkg::MODE_TORQUE)
                     || (controlMode == dsos_pkg::MODE_TORQUE_ZERO);
    assign torqueMag = motorTorque[dsos_pkg::TORQUE_W-1] ? 16'(-motorTorque) : 16'(motorTorque);
    always_comb begin
        if (useAnalogLimit) begin
            limitSel = analogTorqueLimit;
        end else if (motorTorque[dsos_pkg::TORQUE_W-1]) begin
            limitSel = torqueLimitLast;
        end else begin
            limitSel = torqueLimitFirst;
        end
    end
    assign condTorque = !torqueMode && (torqueMag >= 16'(limitSel));

    // ----------------------------------------------------------------
    // next state: codes, threshold, warning
    // ----------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < dsos_pkg::NUM_DO; i++) begin
            code_d[i] = code_q[i];
        end
        if (codeWrite) begin
            code_d[codeIndex] = codeValue;
        end
        zeroThr_d = zeroSpeedLoad ? zeroSpeedValue : zeroThr_q;
        warn_d = |warnFaults;
        warnSeen_d = |warnFaults;
    end

    // per output function select
    for (genvar g = 0; g < dsos_pkg::NUM_DO; g++) begin : g_out
        always_comb begin
            case (code_q[g])
                dsos_pkg::FN_READY: out_d[g] = condReady;
                dsos_pkg::FN_POWER_ON: out_d[g] = condPower;
                dsos_pkg::FN_ZERO_SPEED: out_d[g] = condZero;
                dsos_pkg::FN_TARGET_SPEED: out_d[g] = condTarget;
                dsos_pkg::FN_IN_POSITION: out_d[g] = condInPos;
                dsos_pkg::FN_TORQUE_LIMIT: out_d[g] = condTorque;
                dsos_pkg::FN_ALARM: out_d[g] = condAlarm;
                dsos_pkg::FN_BRAKE: out_d[g] = condBrake;
                default: out_d[g] = 1'b0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < dsos_pkg::NUM_DO; i++) begin
                code_q[i] <= dsos_pkg::CODE_RESET;
            end
            out_q <= '0;
            warn_q <= 1'b0;
            warnSeen_q <= 1'b0;
            zeroThr_q <= dsos_pkg::ZERO_SPEED_DEFAULT_RPM;
        end else begin
            for (int i = 0; i < dsos_pkg::NUM_DO; i++) begin
                code_q[i] <= code_d[i];
            end
            out_q <= out_d;
            warn_q <= warn_d;
            warnSeen_q <= warnSeen_d;
            zeroThr_q <= zeroThr_d;
        end
    end

    assign digitalOut = out_q;
    assign warningOut = warn_q;
    assign zeroSpeedThreshold = zeroThr_q;

    // ----------------------------------------------------------------
    // checks on output 0 and the zero speed threshold
    // ----------------------------------------------------------------
    chk_ready_no_alarm: assert property (@(posedge clock) disable iff (!rst_n)
        (code_q[0] == dsos_pkg::FN_READY) && otherAlarm |=> !digitalOut[0])
        else $error("ready output high during alarm");

    chk_power_on_level: assert property (@(posedge clock) disable iff (!rst_n)
        (code_q[0] == dsos_pkg::FN_POWER_ON) |=> digitalOut[0] == $past(controlPowerOn))
        else $error("power output not following control power");

    chk_zero_speed: assert property (@(posedge clock) disable iff (!rst_n)
        (code_q[0] == dsos_pkg::FN_ZERO_SPEED) |=>
        digitalOut[0] == ($past(motorSpeed) <= $past(zeroThr_q)))
        else $error("zero speed output wrong");

    chk_zero_default: assert property (@(posedge clock)
        $rose(rst_n) |-> zeroThr_q == 16'h000A)
        else $error("zero speed threshold not at default");

    chk_target_speed: assert property (@(posedge clock) disable iff (!rst_n)
        (code_q[0] == dsos_pkg::FN_TARGET_SPEED) && (motorSpeed < targetSpeedSetting)
        |=> !digitalOut[0])
        else $error("target speed output high below target");

    chk_in_pos_pulse: assert property (@(posedge clock) disable iff (!rst_n)
        (code_q[0] == dsos_pkg::FN_IN_POSITION) && (controlMode == dsos_pkg::MODE_EXT_PULSE)
        && (positionError == '0) |=> digitalOut[0])
        else $error("in position low at zero error");

    chk_in_pos_band: assert property (@(posedge clock) disable iff (!rst_n)
        (code_q[0] == dsos_pkg::FN_IN_POSITION) && (controlMode == dsos_pkg::MODE_INT_REG)
        && (diffMag > 33'(inPositionWindow)) |=> !digitalOut[0])
        else $error("in position high outside band");

    chk_torque_mode: assert property (@(posedge clock) disable iff (!rst_n)
        (code_q[0] == dsos_pkg::FN_TORQUE_LIMIT) && torqueMode |=> !digitalOut[0])
        else $error("torque limit output in torque mode");

    chk_warn_first: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(warningOut) && !$past(otherAlarm) && (code_q[0] == dsos_pkg::FN_ALARM)
        && $stable(code_q[0]) |-> !digitalOut[0])
        else $error("alarm not later than warning");

    chk_alarm_follow: assert property (@(posedge clock) disable iff (!rst_n)
        (code_q[0] == dsos_pkg::FN_ALARM) && otherAlarm ##1 (code_q[0] == dsos_pkg::FN_ALARM)
        |-> digitalOut[0])
        else $error("alarm output missing");

    chk_brake_select: assert property (@(posedge clock) disable iff (!rst_n)
        (code_q[0] == dsos_pkg::FN_BRAKE) |=> digitalOut[0] == $past(brakeActive))
        else $error("brake output not following brake timer");

    chk_undefined_low: assert property (@(posedge clock) disable iff (!rst_n)
        (code_q[0] == 8'h00) || (code_q[0] > 8'h08) |=> !digitalOut[0])
        else $error("undefined code drives output");

endmodule

// [testbench/dsos_controller_model.sv]
`timescale 1ns/100ps
module dsos_controller_model (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // drive status lines
    input wire logic [dsos_pkg::NUM_DO-1:0] digitalOut,
    input wire logic warningOut,
    // lines seen high since reset
    output logic [dsos_pkg::NUM_DO:0] seenHigh
);
    // ------------------------------------------------
    // controller input latch
    // ------------------------------------------------
    // sticky record of every status line the controller saw asserted
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            seenHigh <= '0;
        end else begin
            seenHigh <= seenHigh | {warningOut, digitalOut};
        end
    end
endmodule

// [testbench/dsos_output_select_test.sv]
`timescale 1ns/100ps
module dsos_output_select_test;
    // ------------------------------------------------
    // signals
    // ------------------------------------------------
    typedef struct packed {
        logic [2:0] mode;
        logic pwr, rdy, alm;
        logic [4:0] warn;
        logic [15:0] speed;
        logic [31:0] perr, mpos;
        logic [15:0] torque;
        logic [7:0] expOut;
    } dsos_row_t;
    logic clock, rst_n, codeWrite, zeroSpeedLoad, controlPowerOn, driveReady, otherAlarm;
    logic useAnalogLimit, brakeRequest, warningOut;
    logic [2:0] codeIndex, controlMode;
    logic [7:0] codeValue, digitalOut;
    logic [4:0] warnFaults;
    logic [15:0] motorSpeed, zeroSpeedValue, targetSpeedSetting, zeroSpeedThreshold;
    logic [15:0] brakeOnDelay, brakeOffDelay;
    logic signed [31:0] positionError, motorPosition, targetPosition;
    logic [30:0] inPositionWindow;
    logic signed [15:0] motorTorque;
    logic [14:0] torqueLimitFirst, torqueLimitLast, analogTorqueLimit;
    logic [8:0] seenHigh;
    logic [7:0] badCodes [3] = '{8'h00, 8'h09, 8'hFF};
    int errors = 0;
    int compares = 0;
    int cycles = 0;
    dsos_row_t rows [12] = '{
        '{3'h0, 1'h1, 1'h1, 1'h0, 5'h00, 16'h000A, 32'h5, 32'h0, 16'h0000, 8'h17},
        '{3'h0, 1'h1, 1'h1, 1'h0, 5'h00, 16'h000B, 32'h6, 32'h0, 16'h0000, 8'h03},
        '{3'h1, 1'h1, 1'h1, 1'h0, 5'h00, 16'h0064, 32'h0, 32'h3E3, 16'h0000, 8'h1B},
        '{3'h1, 1'h1, 1'h1, 1'h0, 5'h00, 16'h0063, 32'h0, 32'h3EE, 16'h0000, 8'h03},
        '{3'h2, 1'h1, 1'h1, 1'h0, 5'h00, 16'h00C8, 32'h0, 32'h0, 16'h0032, 8'h2B},
        '{3'h3, 1'h1, 1'h1, 1'h0, 5'h00, 16'h00C8, 32'h0, 32'h0, 16'h0032, 8'h0B},
        '{3'h5, 1'h1, 1'h1, 1'h0, 5'h00, 16'h00C8, 32'h0, 32'h0, 16'hFFD8, 8'h0B},
        '{3'h2, 1'h1, 1'h1, 1'h0, 5'h00, 16'h00C8, 32'h0, 32'h0, 16'hFFD8, 8'h2B},
        '{3'h2, 1'h1, 1'h1, 1'h0, 5'h00, 16'h00C8, 32'h0, 32'h0, 16'hFFD9, 8'h0B},
        '{3'h2, 1'h1, 1'h1, 1'h1, 5'h00, 16'h0000, 32'h0, 32'h0, 16'h0000, 8'h46},
        '{3'h4, 1'h0, 1'h0, 1'h0, 5'h00, 16'h0000, 32'h0, 32'h0, 16'h0000, 8'h04},
        '{3'h2, 1'h1, 1'h1, 1'h0, 5'h10, 16'h0000, 32'h0, 32'h0, 16'h0000, 8'h46}};
    // design and controller
    dsos_output_select #(.CYCLES_PER_MS(4)) uut (.clock(clock), .rst_n(rst_n),
        .codeWrite(codeWrite), .codeIndex(codeIndex), .codeValue(codeValue),
        .controlMode(controlMode), .controlPowerOn(controlPowerOn), .driveReady(driveReady),
        .otherAlarm(otherAlarm), .warnFaults(warnFaults), .motorSpeed(motorSpeed),
        .zeroSpeedLoad(zeroSpeedLoad), .zeroSpeedValue(zeroSpeedValue),
        .targetSpeedSetting(targetSpeedSetting), .positionError(positionError),
        .motorPosition(motorPosition), .targetPosition(targetPosition),
        .inPositionWindow(inPositionWindow), .motorTorque(motorTorque),
        .torqueLimitFirst(torqueLimitFirst), .torqueLimitLast(torqueLimitLast),
        .useAnalogLimit(useAnalogLimit), .analogTorqueLimit(analogTorqueLimit),
        .brakeRequest(brakeRequest), .brakeOnDelay(brakeOnDelay),
        .brakeOffDelay(brakeOffDelay), .digitalOut(digitalOut), .warningOut(warningOut),
        .zeroSpeedThreshold(zeroSpeedThreshold));
    dsos_controller_model ctrl (.clock(clock), .rst_n(rst_n), .digitalOut(digitalOut),
        .warningOut(warningOut), .seenHigh(seenHigh));
    // ------------------------------------------------
    // helpers
    // ------------------------------------------------
    // clock at 100 MHz
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            wrap_up();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] expv);
        compares++;
        if (seen !== expv) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, expv);
        end
    endtask
    task automatic setCode(input logic [2:0] idx, input logic [7:0] val);
        @(posedge clock);
        codeWrite <= 1'b1;
        codeIndex <= idx;
        codeValue <= val;
    endtask
    task automatic endWrite();
        @(posedge clock);
        codeWrite <= 1'b0;
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic waitOut(input int idx, input logic v, input int n);
        for (int k = 0; k < n && digitalOut[idx] !== v; k++) @(negedge clock);
    endtask
    task automatic applyRow(input dsos_row_t r);
        @(posedge clock);
        controlMode <= r.mode;
        controlPowerOn <= r.pwr;
        driveReady <= r.rdy;
        otherAlarm <= r.alm;
        warnFaults <= r.warn;
        motorSpeed <= r.speed;
        positionError <= r.perr;
        motorPosition <= r.mpos;
        motorTorque <= r.torque;
        settle(4);
    endtask
    task automatic wrap_up();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ------------------------------------------------
    // sequence
    // ------------------------------------------------
    initial begin
        {rst_n, codeWrite, zeroSpeedLoad, otherAlarm, useAnalogLimit, brakeRequest} = '0;
        {codeIndex, codeValue, warnFaults, motorSpeed, zeroSpeedValue, positionError} = '0;
        {controlMode, controlPowerOn, driveReady, motorPosition, motorTorque} = '0;
        {brakeOnDelay, brakeOffDelay} = {16'h0002, 16'h0001};
        {targetSpeedSetting, targetPosition, inPositionWindow} = {16'h0064, 32'h3E8, 31'h5};
        {torqueLimitFirst, torqueLimitLast, analogTorqueLimit} = {15'h32, 15'h28, 15'h1E};
        settle(11);
        check(digitalOut, 8'h00);
        check(zeroSpeedThreshold, 16'h000A);
        @(posedge clock);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) setCode(i[2:0], 8'(i + 1));
        endWrite();
        foreach (rows[i]) begin
            applyRow(rows[i]);
            check(digitalOut, rows[i].expOut);
        end
        // each listed fault shows as warning before alarm
        for (int f = 0; f < 5; f++) begin
            applyRow(rows[4]);
            @(posedge clock);
            warnFaults <= 5'(1 << f);
            for (int k = 0; k < 4 && warningOut !== 1'b1; k++) @(negedge clock);
            check(warningOut, 1'b1);
            check(digitalOut[6], 1'b0);
            settle(2);
            check(digitalOut[6], 1'b1);
            check(digitalOut[0], 1'b0);
        end
        // slot 0 walks functions 2 to 8 over all rows so its checks see traffic
        for (int c = 2; c <= 8; c++) begin
            setCode(3'h0, 8'(c));
            endWrite();
            foreach (rows[i]) begin
                applyRow(rows[i]);
                check(digitalOut[0], rows[i].expOut[c-1]);
            end
        end
        // undefined codes keep the line low while ready holds
        applyRow(rows[4]);
        foreach (badCodes[i]) begin
            setCode(3'h0, badCodes[i]);
            endWrite();
            settle(3);
            check(digitalOut[0], 1'b0);
        end
        setCode(3'h0, 8'h01);
        endWrite();
        settle(3);
        check(digitalOut[0], 1'b1);
        // loaded zero speed threshold is inclusive
        @(posedge clock);
        zeroSpeedLoad <= 1'b1;
        zeroSpeedValue <= 16'h0014;
        @(posedge clock);
        zeroSpeedLoad <= 1'b0;
        motorSpeed <= 16'h0014;
        settle(3);
        check(zeroSpeedThreshold, 16'h0014);
        check(digitalOut[2], 1'b1);
        @(posedge clock);
        motorSpeed <= 16'h0015;
        settle(3);
        check(digitalOut[2], 1'b0);
        // analog torque limit overrides the parameters
        @(posedge clock);
        useAnalogLimit <= 1'b1;
        motorTorque <= 16'h001E;
        settle(3);
        check(digitalOut[5], 1'b1);
        @(posedge clock);
        motorTorque <= 16'h001D;
        settle(3);
        check(digitalOut[5], 1'b0);
        // brake engages after 8 cycles, releases after 4
        @(posedge clock);
        brakeRequest <= 1'b1;
        settle(5);
        check(digitalOut[7], 1'b0);
        waitOut(7, 1'b1, 9);
        check(digitalOut[7], 1'b1);
        @(posedge clock);
        brakeRequest <= 1'b0;
        settle(2);
        check(digitalOut[7], 1'b1);
        waitOut(7, 1'b0, 8);
        check(digitalOut[7], 1'b0);
        check(seenHigh, 9'h1FF);
        // zero delays engage and release the brake at once
        @(posedge clock);
        brakeOnDelay <= '0;
        brakeOffDelay <= '0;
        brakeRequest <= 1'b1;
        settle(3);
        check(digitalOut[7], 1'b1);
        @(posedge clock);
        brakeRequest <= 1'b0;
        settle(3);
        check(digitalOut[7], 1'b0);
        // reset in mid-run clears stored codes
        @(posedge clock);
        rst_n <= 1'b0;
        settle(1);
        check(digitalOut, 8'h00);
        @(posedge clock);
        rst_n <= 1'b1;
        settle(3);
        check(digitalOut, 8'h00);
        check(zeroSpeedThreshold, 16'h000A);
        wrap_up();
    end
endmodule
